// ===== cpt_pkg.sv
`default_nettype none
package cpt_pkg;
	localparam logic [7:0] CPT_OFS_CTRL0 = 8'h00;
	localparam logic [7:0] CPT_OFS_CTRL1 = 8'h04;
	localparam logic [7:0] CPT_OFS_CNT_LO = 8'h08;
	localparam logic [7:0] CPT_OFS_CNT_HI = 8'h0c;
	localparam logic [7:0] CPT_OFS_CMPA_LO = 8'h10;
	localparam logic [7:0] CPT_OFS_CMPA_HI = 8'h14;
	localparam logic [7:0] CPT_OFS_PERIOD = 8'h18;

	localparam logic [2:0] CPT_CLK_SYS_DIV4 = 3'h0;
	localparam logic [2:0] CPT_CLK_SYS = 3'h1;
	localparam logic [2:0] CPT_CLK_FH_DIV16 = 3'h2;
	localparam logic [2:0] CPT_CLK_FH_DIV64 = 3'h3;
	localparam logic [2:0] CPT_CLK_SUB_A = 3'h4;
	localparam logic [2:0] CPT_CLK_SUB_B = 3'h5;
	localparam logic [2:0] CPT_CLK_EXT_RISE = 3'h6;
	localparam logic [2:0] CPT_CLK_EXT_FALL = 3'h7;

	localparam logic [5:0] CPT_DIV4_MASK = 6'h03;
	localparam logic [5:0] CPT_DIV16_MASK = 6'h0f;
	localparam logic [5:0] CPT_DIV64_MASK = 6'h3f;

	localparam logic [1:0] CPT_ACT_NONE = 2'h0;
	localparam logic [1:0] CPT_ACT_LOW = 2'h1;
	localparam logic [1:0] CPT_ACT_HIGH = 2'h2;
	localparam logic [1:0] CPT_ACT_TOGGLE = 2'h3;
	localparam logic [1:0] CPT_PWM_INACTIVE = 2'h0;
	localparam logic [1:0] CPT_PWM_ACTIVE = 2'h1;
	localparam logic [1:0] CPT_PWM_WAVE = 2'h2;

	localparam logic [15:0] CPT_CNT_RST = 16'h0000;
	localparam logic [15:0] CPT_CMPA_RST = 16'h0000;
	localparam logic [7:0] CPT_PERIOD_RST = 8'h00;
	localparam logic [7:0] CPT_HOLD_RST = 8'h00;
	localparam logic [4:0] CPT_CTRL0_RST = 5'h00;
	localparam logic [7:0] CPT_CTRL1_RST = 8'h00;

	typedef enum logic [1:0] {
		CPT_MODE_CMP = 2'b00,
		CPT_MODE_UNDEF = 2'b01,
		CPT_MODE_TMR = 2'b11,
		CPT_MODE_PWM = 2'b10
	} cpt_mode_e;

	typedef struct packed {
		logic pause_bit;
		logic [2:0] clock_select_field;
		logic timer_on_bit;
	} cpt_ctrl0_s;

	typedef struct packed {
		cpt_mode_e mode_select_field;
		logic [1:0] pin_action_field;
		logic output_initial_level;
		logic output_invert_bit;
		logic duty_period_swap;
		logic clear_source_select;
	} cpt_ctrl1_s;
endpackage
`default_nettype wire

// ===== cpt_timer.sv
// What this block does
// - Separate interrupt pulses for comparator A and comparator P matches.
// - A compare match can clear the counter and change the output pin.
// - External clock pin counts only when the clock select field picks it.
// - External clock counts on rising or falling edge as selected.
// - Compare mode: match drives pin high, low or toggles as configured.
// - The same output pin carries the PWM waveform in PWM mode.
// - High bytes are direct; low bytes go through one shared 8-bit buffer.
// - Low write fills buffer; high write stores high and copies buffer low.
// - High read returns high and captures low; low read returns buffer.
// - Three modes: compare match output, timer/counter, PWM output.
// - Core is a 16-bit up-counter on internal or external clock.
// - Comparator P matches its 8-bit value to the counter's upper byte.
// - Comparator A matches its 16-bit value to the whole counter.
// - Software can only clear the counter, via the on bit rising.
// - Counter clears on overflow or selected comparator match.
// - Counter is read-only pair, A is read/write pair, P is one byte.
// - Two control registers hold all clock, mode and output settings.
// - Mode 00 compare output, 10 PWM, 11 timer/counter, 01 undefined.
// - Pause freezes the counter; clearing it resumes from that value.
// - Outside PWM, clear-select high: A match clears; low: P match or overflow clears.
`timescale 1ns/1ps
`default_nettype none
module cpt_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic compact_ext_clock_pin,
	input wire logic sub_clock_pin,
	output logic compact_output_pin,
	output logic irq_compare_a,
	output logic irq_compare_p
);
	import cpt_pkg::*;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	cpt_ctrl0_s ctrl0_q;
	cpt_ctrl1_s ctrl1_q;
	logic [15:0] cnt_q, cnt_d;
	logic [15:0] cmpa_q;
	logic [7:0] period_q;
	logic [7:0] hold_q;
	logic on_prev_q;
	logic [5:0] pres_q;
	logic [2:0] ext_sync_q;
	logic [2:0] sub_sync_q;
	logic out_q, out_d;
	logic pin_q;
	logic irq_a_q, irq_p_q;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q;

	// Two flops synchronise each pin; the third stage only serves edge detection.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_sync_q <= 3'h0;
			sub_sync_q <= 3'h0;
			pres_q <= 6'h00;
		end else begin
			ext_sync_q <= {ext_sync_q[1:0], compact_ext_clock_pin};
			sub_sync_q <= {sub_sync_q[1:0], sub_clock_pin};
			pres_q <= pres_q + 6'h01;
		end
	end

	wire ext_rise = ext_sync_q[1] & ~ext_sync_q[2];
	wire ext_fall = ~ext_sync_q[1] & ext_sync_q[2];
	wire sub_rise = sub_sync_q[1] & ~sub_sync_q[2];

	function automatic logic clk_tick(input logic [2:0] sel, input logic [5:0] pres, input logic er,
		input logic ef, input logic sr);
		case (sel)
			CPT_CLK_SYS_DIV4: clk_tick = (pres & CPT_DIV4_MASK) == CPT_DIV4_MASK;
			CPT_CLK_SYS: clk_tick = 1'b1;
			CPT_CLK_FH_DIV16: clk_tick = (pres & CPT_DIV16_MASK) == CPT_DIV16_MASK;
			CPT_CLK_FH_DIV64: clk_tick = (pres & CPT_DIV64_MASK) == CPT_DIV64_MASK;
			CPT_CLK_SUB_A, CPT_CLK_SUB_B: clk_tick = sr;
			CPT_CLK_EXT_RISE: clk_tick = er;
			CPT_CLK_EXT_FALL: clk_tick = ef;
			default: clk_tick = 1'b0;
		endcase
	endfunction

	// The pin edge only reaches the counter through the select decode.
	wire src_tick = clk_tick(ctrl0_q.clock_select_field, pres_q, ext_rise, ext_fall, sub_rise);
	wire on_rise = ctrl0_q.timer_on_bit & ~on_prev_q;
	wire run = ctrl0_q.timer_on_bit & ~ctrl0_q.pause_bit & ~on_rise;
	wire tick = run & src_tick;
	wire [15:0] cnt_inc = cnt_q + 16'h0001;

	// A match is the moment the counter arrives at the compare value.
	wire hit_a = cnt_inc == cmpa_q;
	wire hit_p = (cnt_inc[15:8] == period_q) && (cnt_inc[7:0] == 8'h00);
	wire match_a = tick & hit_a;
	wire match_p = tick & hit_p;

	// In PWM mode the period comparator follows the swap bit, not clear-select.
	wire is_pwm = ctrl1_q.mode_select_field == CPT_MODE_PWM;
	wire clear_by_a = is_pwm ? ctrl1_q.duty_period_swap : ctrl1_q.clear_source_select;
	// A period of zero matches only at the wrap, which gives the overflow clear.
	wire clear_now = clear_by_a ? match_a : match_p;

	always_comb begin
		cnt_d = cnt_q;
		if (on_rise) begin
			cnt_d = CPT_CNT_RST;
		end else if (clear_now) begin
			cnt_d = CPT_CNT_RST;
		end else if (tick) begin
			cnt_d = cnt_inc;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= CPT_CNT_RST;
			on_prev_q <= 1'b0;
			irq_a_q <= 1'b0;
			irq_p_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			on_prev_q <= ctrl0_q.timer_on_bit;
			irq_a_q <= match_a;
			irq_p_q <= match_p;
		end
	end

	a_on_clears_cnt: assert property (on_rise |=> cnt_q == CPT_CNT_RST)
		else $error("Counter not cleared when the timer was switched on.");
	a_pause_holds_cnt: assert property (ctrl0_q.pause_bit && ctrl0_q.timer_on_bit && on_prev_q
		|=> $stable(cnt_q))
		else $error("Counter moved while paused.");
	a_wrap_to_zero: assert property (tick && cnt_q == 16'hffff |=> cnt_q == CPT_CNT_RST)
		else $error("Counter did not wrap to zero.");

	sequence s_a_arrive;
		tick && (cnt_inc == cmpa_q);
	endsequence
	// With A of one and A-clear, matches come back to back, so the pulse is checked per match.
	a_irq_a_match: assert property (s_a_arrive |=> irq_a_q)
		else $error("Comparator A match did not raise its interrupt.");
	a_irq_a_quiet: assert property (!match_a |=> !irq_a_q)
		else $error("Comparator A interrupt without a match.");
	a_irq_p_quiet: assert property (!match_p |=> !irq_p_q)
		else $error("Comparator P interrupt without a match.");
	a_irq_p_upper: assert property (irq_p_q |-> $past(cnt_inc[15:8]) == $past(period_q)
		&& $past(cnt_inc[7:0]) == 8'h00)
		else $error("Comparator P interrupt without an upper byte match.");
	a_clear_on_a: assert property (s_a_arrive and (clear_by_a && !on_rise) |=> cnt_q == CPT_CNT_RST)
		else $error("Comparator A match did not clear the counter.");
	a_ext_needs_sel: assert property (tick && ctrl0_q.clock_select_field[2:1] != 2'b11
		|-> !(ext_rise || ext_fall) || src_tick == clk_tick(ctrl0_q.clock_select_field, pres_q, 1'b0, 1'b0,
		sub_rise))
		else $error("External pin advanced the counter while not selected.");

	// Output pin logic.
	wire [1:0] act = ctrl1_q.pin_action_field;
	wire duty_src_p = ctrl1_q.duty_period_swap;
	wire pwm_on = duty_src_p ? (cnt_q[15:8] < period_q) : (cnt_q < cmpa_q);
	wire active_lvl = ctrl1_q.output_initial_level;

	always_comb begin
		out_d = out_q;
		case (ctrl1_q.mode_select_field)
			CPT_MODE_CMP: begin
				if (on_rise) begin
					out_d = ctrl1_q.output_initial_level;
				end else if (match_a) begin
					case (act)
						CPT_ACT_LOW: out_d = 1'b0;
						CPT_ACT_HIGH: out_d = 1'b1;
						CPT_ACT_TOGGLE: out_d = ~out_q;
						default: out_d = out_q;
					endcase
				end
			end
			CPT_MODE_PWM: begin
				case (act)
					CPT_PWM_INACTIVE: out_d = ~active_lvl;
					CPT_PWM_ACTIVE: out_d = active_lvl;
					CPT_PWM_WAVE: out_d = ctrl0_q.timer_on_bit ? (pwm_on ? active_lvl : ~active_lvl) : out_q;
					default: out_d = out_q;
				endcase
			end
			default: out_d = out_q;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_q <= 1'b0;
			pin_q <= 1'b0;
		end else begin
			out_q <= out_d;
			pin_q <= out_d ^ ctrl1_q.output_invert_bit;
		end
	end

	logic pwm_on_prev, active_prev, invert_prev;
	a_toggle_out: assert property (ctrl1_q.mode_select_field == CPT_MODE_CMP && act == CPT_ACT_TOGGLE
		&& match_a && !on_rise |=> out_q != $past(out_q))
		else $error("Toggle action did not toggle the output.");
	a_pwm_pin_wave: assert property (is_pwm && act == CPT_PWM_WAVE && ctrl0_q.timer_on_bit
		|=> compact_output_pin == ((pwm_on_prev ? active_prev : ~active_prev) ^ invert_prev))
		else $error("PWM waveform missing on the output pin.");
	always_ff @(posedge pclk) begin
		pwm_on_prev <= pwm_on;
		active_prev <= active_lvl;
		invert_prev <= ctrl1_q.output_invert_bit;
	end

	// APB slave with one wait state; writes land on the completing edge, read captures on the wait-state edge.
	wire setup_acc = psel & penable & ~pready_q;
	wire fire = psel & penable & pready_q;
	wire wr = fire & pwrite;
	wire rd_cap = setup_acc & ~pwrite;
	wire sel_c0 = paddr == CPT_OFS_CTRL0;
	wire sel_c1 = paddr == CPT_OFS_CTRL1;
	wire sel_dl = paddr == CPT_OFS_CNT_LO;
	wire sel_dh = paddr == CPT_OFS_CNT_HI;
	wire sel_al = paddr == CPT_OFS_CMPA_LO;
	wire sel_ah = paddr == CPT_OFS_CMPA_HI;
	wire sel_rp = paddr == CPT_OFS_PERIOD;
	wire mapped = sel_c0 | sel_c1 | sel_dl | sel_dh | sel_al | sel_ah | sel_rp;
	wire [7:0] rd_byte = sel_c0 ? {ctrl0_q, 3'h0} :
		sel_c1 ? ctrl1_q :
		sel_dh ? cnt_q[15:8] :
		sel_ah ? cmpa_q[15:8] :
		sel_rp ? period_q :
		(sel_dl | sel_al) ? hold_q : 8'h00;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= setup_acc;
			pslverr_q <= setup_acc & ~mapped;
			if (rd_cap) begin
				prdata_q <= {24'h00_0000, rd_byte};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl0_q <= CPT_CTRL0_RST;
			ctrl1_q <= CPT_CTRL1_RST;
			cmpa_q <= CPT_CMPA_RST;
			period_q <= CPT_PERIOD_RST;
			hold_q <= CPT_HOLD_RST;
		end else begin
			if (wr && sel_c0) begin
				ctrl0_q <= pwdata[7:3];
			end
			if (wr && sel_c1) begin
				ctrl1_q <= pwdata[7:0];
			end
			if (wr && sel_rp) begin
				period_q <= pwdata[7:0];
			end
			if (wr && sel_ah) begin
				cmpa_q <= {pwdata[7:0], hold_q};
			end
			if (wr && sel_al) begin
				hold_q <= pwdata[7:0];
			end else if (rd_cap && sel_dh) begin
				hold_q <= cnt_q[7:0];
			end else if (rd_cap && sel_ah) begin
				hold_q <= cmpa_q[7:0];
			end
		end
	end

	a_low_write_buf: assert property (wr && sel_al |=> hold_q == $past(pwdata[7:0]) && $stable(cmpa_q))
		else $error("Low byte write did more than fill the buffer.");
	a_high_write_copy: assert property (wr && sel_ah |=> cmpa_q == {$past(pwdata[7:0]), $past(hold_q)})
		else $error("High byte write did not copy the buffer into the low byte.");
	a_high_read_cap: assert property (rd_cap && sel_dh |=> hold_q == $past(cnt_q[7:0])
		&& prdata_q[7:0] == $past(cnt_q[15:8]))
		else $error("Counter high read did not capture the low byte.");
	a_ready_one_wait: assert property (setup_acc |=> pready_q ##1 !pready_q)
		else $error("Ready was not a single cycle after one wait state.");
	a_err_unmapped: assert property (setup_acc |=> pslverr_q == !$past(mapped))
		else $error("Error response does not match the address decode.");

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign compact_output_pin = pin_q;
	assign irq_compare_a = irq_a_q;
	assign irq_compare_p = irq_p_q;
endmodule // cpt_timer
`default_nettype wire

// ===== cpt_timer_dummy_none.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== cpt_ext_src.sv
`timescale 1ns/1ps
`default_nettype none
// Outside world: an event source on the count pin and a slow sub clock, both idle low.
module cpt_ext_src (
	input wire logic pclk,
	output logic ext_clk,
	output logic sub_clk
);
	initial begin
		ext_clk = 1'b0;
		sub_clk = 1'b0;
	end
	// Each level is held six cycles so that the two-stage synchroniser sees every edge.
	task automatic burst(input logic use_sub, input int n);
		repeat (n) begin
			repeat (6) @(posedge pclk);
			if (use_sub)
				sub_clk <= 1'b1;
			else
				ext_clk <= 1'b1;
			repeat (6) @(posedge pclk);
			if (use_sub)
				sub_clk <= 1'b0;
			else
				ext_clk <= 1'b0;
		end
		repeat (8) @(posedge pclk);
	endtask
endmodule // cpt_ext_src
`default_nettype wire

// ===== cpt_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cpt_timer_tb;
	import cpt_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, ext_pin, sub_pin, out_pin, irq_a, irq_p;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rv;
	logic [15:0] v1, v2;
	int n_errors = 0;
	int total_checks = 0;
	int cyc = 0;
	int t1, t2, hc;
	logic [7:0] c1 [4] = '{8'h21, 8'h19, 8'h31, 8'h09};
	logic [2:0] pe [4] = '{3'b011, 3'b100, 3'b010, 3'b111};
	logic [7:0] pw [4] = '{8'ha8, 8'hac, 8'h88, 8'h98};
	int pwx [4] = '{64, 192, 0, 256};
	logic [2:0] es [4] = '{CPT_CLK_EXT_RISE, CPT_CLK_EXT_FALL, CPT_CLK_SUB_A, CPT_CLK_SUB_A};
	int ex [4] = '{5, 5, 0, 5};

	cpt_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.compact_ext_clock_pin(ext_pin), .sub_clock_pin(sub_pin), .compact_output_pin(out_pin),
		.irq_compare_a(irq_a), .irq_compare_p(irq_p));
	cpt_ext_src src (.pclk(pclk), .ext_clk(ext_pin), .sub_clk(sub_pin));

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task automatic give_verdict;
		if (n_errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_errors++;
			give_verdict();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// The request is held until pready is sampled high; one idle edge follows so psel never toggles twice at once.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 8'h00);
		check(rv, exp);
	endtask

	task automatic rd16(output logic [15:0] v);
		apb(1'b0, CPT_OFS_CNT_HI, 8'h00);
		v[15:8] = rv[7:0];
		apb(1'b0, CPT_OFS_CNT_LO, 8'h00);
		v[7:0] = rv[7:0];
	endtask

	task automatic wait_irq(input logic on_p, output int t);
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while ((on_p ? irq_p : irq_a) !== 1'b1 && n < 1000);
		if (n >= 1000)
			n_errors++;
		t = cyc;
	endtask

	initial begin
		{psel, penable, pwrite, paddr, pwdata, presetn} = '0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 7; i++)
			rd(8'(i * 4), 32'h0);
		apb(1'b0, 8'h1c, 8'h00);
		check({31'h0, err}, 32'h1);
		wr(CPT_OFS_CTRL0, 8'hff);
		rd(CPT_OFS_CTRL0, 32'hf8);
		wr(CPT_OFS_CTRL1, 8'h5a);
		rd(CPT_OFS_CTRL1, 32'h5a);
		wr(CPT_OFS_CTRL0, 8'h00);
		wr(CPT_OFS_CNT_HI, 8'hff);
		rd(CPT_OFS_CNT_HI, 32'h0);
		wr(CPT_OFS_CMPA_LO, 8'h10);
		rd(CPT_OFS_CMPA_HI, 32'h0);
		rd(CPT_OFS_CMPA_LO, 32'h0);
		wr(CPT_OFS_CMPA_LO, 8'h10);
		wr(CPT_OFS_CMPA_HI, 8'h00);
		rd(CPT_OFS_CMPA_HI, 32'h0);
		rd(CPT_OFS_CMPA_LO, 32'h10);
		wr(CPT_OFS_PERIOD, 8'h01);
		rd(CPT_OFS_PERIOD, 32'h1);
		wr(CPT_OFS_CTRL1, 8'h01);
		wr(CPT_OFS_CTRL0, 8'h18);
		wait_irq(1'b0, t1);
		wait_irq(1'b0, t2);
		check(t2 - t1, 16);
		wr(CPT_OFS_CTRL1, 8'h00);
		wait_irq(1'b1, t1);
		wait_irq(1'b1, t2);
		check(t2 - t1, 256);
		wr(CPT_OFS_CTRL0, 8'h98);
		rd16(v1);
		repeat (10) @(posedge pclk);
		rd16(v2);
		check(v2, v1);
		wr(CPT_OFS_CTRL0, 8'h18);
		rd16(v2);
		check({31'h0, v2 > v1}, 32'h1);
		wr(CPT_OFS_CTRL0, 8'h10);
		wr(CPT_OFS_CTRL0, 8'h18);
		rd16(v2);
		check({31'h0, v2 < 16'h0010}, 32'h1);
		for (int i = 0; i < 4; i++) begin
			wr(CPT_OFS_CTRL0, {1'b0, es[i], 4'h0});
			wr(CPT_OFS_CTRL0, {1'b0, es[i], 4'h8});
			src.burst(i == 3, 5);
			rd16(v2);
			check(v2, ex[i]);
		end
		wr(CPT_OFS_PERIOD, 8'h01);
		for (int i = 0; i < 4; i++) begin
			wr(CPT_OFS_CTRL0, 8'h10);
			wr(CPT_OFS_CTRL1, c1[i]);
			wr(CPT_OFS_CTRL0, 8'h18);
			repeat (2) @(posedge pclk);
			check(out_pin, pe[i][2]);
			wait_irq(1'b0, t1);
			repeat (3) @(posedge pclk);
			check(out_pin, pe[i][1]);
			wait_irq(1'b0, t1);
			repeat (3) @(posedge pclk);
			check(out_pin, pe[i][0]);
		end
		wr(CPT_OFS_CMPA_LO, 8'h40);
		wr(CPT_OFS_CMPA_HI, 8'h00);
		// Any 256 consecutive samples span exactly one PWM period, whatever the phase.
		for (int i = 0; i < 4; i++) begin
			wr(CPT_OFS_CTRL0, 8'h10);
			wr(CPT_OFS_CTRL1, pw[i]);
			wr(CPT_OFS_CTRL0, 8'h18);
			repeat (4) @(posedge pclk);
			hc = 0;
			repeat (256) begin
				@(posedge pclk);
				hc += int'(out_pin === 1'b1);
			end
			check(hc, pwx[i]);
		end
		give_verdict();
	end
endmodule // cpt_timer_tb
`default_nettype wire
